/* hdl/link_cfg_if.sv */
// register access link between controller and servo device
`timescale 1ns/1ps
interface link_cfg_if;
	logic req;
	logic we;
	link_cfg_pkg::reg_idx_t idx;
	logic [31:0] wdata;
	logic ack;
	logic [31:0] rdata;
	modport dev(input req, input we, input idx, input wdata, output ack, output rdata);
	modport ctl(output req, output we, output idx, output wdata, input ack, input rdata);
endinterface

/* hdl/link_cfg_params.svh */
// named constants for the servo network link configuration bank
`ifndef LINK_CFG_PARAMS_SVH
`define LINK_CFG_PARAMS_SVH
`define IDX_TARGET_FLAG_A 3'h0
`define IDX_TSAT 3'h1
`define IDX_CYC 3'h2
`define IDX_RATIO 3'h3
`define IDX_EXT 3'h4
`define RST_TARGET_FLAG_A 30'h0
`define RST_TSAT 16'h0
`define RST_CYC 16'h6
`define RST_RATIO 16'h1
`define RST_EXT 16'h0
`define CYC_C0 16'h0
`define CYC_C1 16'h1
`define CYC_C3 16'h3
`define CYC_C6 16'h6
`define RATIO_ONE 16'h1
`define RATIO_TWO 16'h2
`define EXT_FRAME 0
`define EXT_SYNC 1
`define EXT_RSV 2
`define EXT_UNUSED 3
`define EXT_SCALE 4
`define CLK_NS 8
`define CYC0_NS 83300
`define CYC1_NS 166600
`define CYC3_NS 500000
`define CYC6_NS 1000000
`define CTRL_NS 62500
`define TSAT_MAX 16'h7530
`define A_LAST_REG 8'h10
`define A_STATUS 8'h14
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* hdl/link_cfg_pkg.sv */
// register index type shared by both ends of the configuration link, plus the controller AXI state encoding
package link_cfg_pkg;
	typedef logic [2:0] reg_idx_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WLINK = 3'h1,
		ST_BRESP = 3'h3,
		ST_RLINK = 3'h2,
		ST_RRESP = 3'h6
	} axi_state_t;
endpackage

/* hdl/servo_link_cfg_ctrl.sv */
// host controller end: AXI4-Lite slave that screens and forwards register access
`timescale 1ns/1ps
`include "link_cfg_params.svh"
module servo_link_cfg_ctrl (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// AXI4-Lite slave
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// register link
	link_cfg_if.ctl link
);
	link_cfg_pkg::axi_state_t st_ff, nxt_st;
	logic aw_ff, nxt_aw, w_ff, nxt_w;
	logic [7:0] addr_ff, nxt_addr;
	logic [31:0] data_ff, nxt_data;
	logic [1:0] resp_ff, nxt_resp;
	logic [15:0] cyc_shadow_ff, nxt_cyc_shadow;
	logic [7:0] rej_ff, nxt_rej;
	logic req_ff, nxt_req;
	logic [1:0] strb_ff, nxt_strb;
	logic ratio_two_ff, nxt_ratio_two;

	function automatic logic bad_addr(input logic [7:0] a);
		return a[1:0] != 2'h0 || a > `A_STATUS;
	endfunction

	always_comb begin
		nxt_st = st_ff;
		nxt_aw = aw_ff;
		nxt_w = w_ff;
		nxt_addr = addr_ff;
		nxt_data = data_ff;
		nxt_resp = resp_ff;
		nxt_cyc_shadow = cyc_shadow_ff;
		nxt_rej = rej_ff;
		nxt_req = 1'b0;
		nxt_strb = strb_ff;
		nxt_ratio_two = ratio_two_ff;
		unique case (st_ff)
			link_cfg_pkg::ST_IDLE: begin
				if (o_awready && i_awvalid) begin
					nxt_aw = 1'b1;
					nxt_addr = i_awaddr;
				end
				if (o_wready && i_wvalid) begin
					nxt_w = 1'b1;
					nxt_data = i_wdata;
					// strobes kept with the data, the master may drop them before aw arrives
					nxt_strb = i_wstrb[1:0];
				end
				if (nxt_aw && nxt_w) begin
					nxt_aw = 1'b0;
					nxt_w = 1'b0;
					nxt_resp = `RESP_SLVERR;
					nxt_st = link_cfg_pkg::ST_BRESP;
					// illegal setups other than ratio codes beyond 1 and 2 never reach the device
					if (bad_addr(nxt_addr) || nxt_addr > `A_LAST_REG || nxt_strb != 2'h3) begin
						nxt_rej = rej_ff + 8'h1;
					end else if (nxt_addr[4:2] == `IDX_CYC && !(nxt_data[15:0] == `CYC_C0
						|| nxt_data[15:0] == `CYC_C1 || nxt_data[15:0] == `CYC_C3
						|| nxt_data[15:0] == `CYC_C6)) begin
						nxt_rej = rej_ff + 8'h1;
					end else if (nxt_addr[4:2] == `IDX_RATIO && nxt_data[15:0] == `RATIO_TWO
						&& cyc_shadow_ff != `CYC_C0 && cyc_shadow_ff != `CYC_C3) begin
						nxt_rej = rej_ff + 8'h1;
					end else if (nxt_addr[4:2] == `IDX_CYC && ratio_two_ff && nxt_data[15:0] != `CYC_C0
						&& nxt_data[15:0] != `CYC_C3) begin
						nxt_rej = rej_ff + 8'h1;
					end else begin
						if (nxt_addr[4:2] == `IDX_EXT) begin
							nxt_data[`EXT_RSV] = 1'b0;
							nxt_data[`EXT_UNUSED] = 1'b0;
						end
						if (nxt_addr[4:2] == `IDX_CYC) begin
							nxt_cyc_shadow = nxt_data[15:0];
						end
						if (nxt_addr[4:2] == `IDX_RATIO) begin
							nxt_ratio_two = nxt_data[15:0] == `RATIO_TWO;
						end
						nxt_req = 1'b1;
						nxt_st = link_cfg_pkg::ST_WLINK;
					end
				end else if (o_arready && i_arvalid) begin
					nxt_addr = i_araddr;
					nxt_resp = `RESP_OKAY;
					nxt_st = link_cfg_pkg::ST_RRESP;
					if (bad_addr(i_araddr)) begin
						nxt_resp = `RESP_SLVERR;
						nxt_data = 32'h0;
					end else if (i_araddr == `A_STATUS) begin
						nxt_data = {8'h0, rej_ff, cyc_shadow_ff};
					end else begin
						nxt_req = 1'b1;
						nxt_st = link_cfg_pkg::ST_RLINK;
					end
				end
			end
			link_cfg_pkg::ST_WLINK: begin
				if (link.ack) begin
					nxt_resp = `RESP_OKAY;
					nxt_st = link_cfg_pkg::ST_BRESP;
				end
			end
			link_cfg_pkg::ST_RLINK: begin
				if (link.ack) begin
					nxt_data = link.rdata;
					nxt_st = link_cfg_pkg::ST_RRESP;
				end
			end
			link_cfg_pkg::ST_BRESP: begin
				if (i_bready) begin
					nxt_st = link_cfg_pkg::ST_IDLE;
				end
			end
			link_cfg_pkg::ST_RRESP: begin
				if (i_rready) begin
					nxt_st = link_cfg_pkg::ST_IDLE;
				end
			end
			default: nxt_st = link_cfg_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_ff <= link_cfg_pkg::ST_IDLE;
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			addr_ff <= 8'h0;
			data_ff <= 32'h0;
			resp_ff <= `RESP_OKAY;
			cyc_shadow_ff <= `RST_CYC;
			rej_ff <= 8'h0;
			req_ff <= 1'b0;
			strb_ff <= 2'h0;
			ratio_two_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			aw_ff <= nxt_aw;
			w_ff <= nxt_w;
			addr_ff <= nxt_addr;
			data_ff <= nxt_data;
			resp_ff <= nxt_resp;
			cyc_shadow_ff <= nxt_cyc_shadow;
			rej_ff <= nxt_rej;
			req_ff <= nxt_req;
			strb_ff <= nxt_strb;
			ratio_two_ff <= nxt_ratio_two;
		end
	end

	assign o_awready = st_ff == link_cfg_pkg::ST_IDLE && !aw_ff;
	assign o_wready = st_ff == link_cfg_pkg::ST_IDLE && !w_ff;
	// any write half on offer blocks reads, else a lone aw would lose its address to the read
	assign o_arready = st_ff == link_cfg_pkg::ST_IDLE && !aw_ff && !w_ff && !i_awvalid && !i_wvalid;
	assign o_bvalid = st_ff == link_cfg_pkg::ST_BRESP;
	assign o_bresp = resp_ff;
	assign o_rvalid = st_ff == link_cfg_pkg::ST_RRESP;
	assign o_rresp = resp_ff;
	assign o_rdata = data_ff;
	assign link.req = req_ff;
	assign link.we = st_ff == link_cfg_pkg::ST_WLINK;
	assign link.idx = addr_ff[4:2];
	assign link.wdata = data_ff;
endmodule

/* hdl/servo_link_cfg_device.sv */
// servo device end: configuration bank, cycle timing, target_flag_a flag, torque saturation
// Notes on behaviour
// - target_flag_a flag in profile position mode when target gap below range
// - torque saturated for count cycles raises error
// - zero count disables torque saturation alarm
// - cycle codes 0,1,3,6 pick period
// - controller writes only the four cycle codes
// - controller matches cycle setup to its timing
// - commands update every one or two cycles
// - ratio two only with 0.0833/0.5 ms
// - setup bit 0 selects 16/32 byte frames
// - setup bit 1 selects semi/full sync
// - controller writes zero to bits 2,3
// - setup bit 4 enables semi-closed scale monitor
// - fast cycles forbid scale monitor except no-op
// - full-closed always allows scale monitoring
`timescale 1ns/1ps
`include "link_cfg_params.svh"
module servo_link_cfg_device #(
	parameter int unsigned CYC0_CYCLES = `CYC0_NS / `CLK_NS,
	parameter int unsigned CYC1_CYCLES = `CYC1_NS / `CLK_NS,
	parameter int unsigned CYC3_CYCLES = `CYC3_NS / `CLK_NS,
	parameter int unsigned CYC6_CYCLES = `CYC6_NS / `CLK_NS,
	parameter int unsigned CTRL_CYCLES = `CTRL_NS / `CLK_NS
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// register link
	link_cfg_if.dev link,
	// motion state
	input wire logic i_profile_position_mode,
	input wire logic [31:0] i_target_pos,
	input wire logic [31:0] i_command_pos,
	input wire logic i_torque_sat,
	input wire logic i_alarm_clr,
	input wire logic i_full_closed,
	input wire logic i_no_operation_command,
	// status and derived controls
	output logic o_target_flag_a,
	output logic o_torque_sat_err,
	output logic o_comm_tick,
	output logic o_cmd_update,
	output logic o_ctrl_tick,
	output logic o_frame_32byte,
	output logic o_full_sync,
	output logic o_ext_scale_mon,
	output logic o_cfg_err
);
	logic [29:0] range_ff, nxt_range;
	logic [15:0] tsat_lim_ff, nxt_tsat_lim;
	logic [15:0] cyc_ff, nxt_cyc;
	logic [15:0] ratio_ff, nxt_ratio;
	logic [15:0] ext_ff, nxt_ext;
	logic ack_ff, nxt_ack;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [16:0] comm_cnt_ff, nxt_comm_cnt;
	logic [16:0] ctrl_cnt_ff, nxt_ctrl_cnt;
	logic phase_ff, nxt_phase;
	logic [15:0] sat_cnt_ff, nxt_sat_cnt;
	logic comm_tick_ff, nxt_comm_tick;
	logic cmd_upd_ff, nxt_cmd_upd;
	logic ctrl_tick_ff, nxt_ctrl_tick;
	logic target_flag_a_ff, nxt_target_flag_a;
	logic err_ff, nxt_err;
	logic frame_ff, nxt_frame;
	logic sync_ff, nxt_sync;
	logic scale_ff, nxt_scale;
	logic cfg_err_ff, nxt_cfg_err;

	function automatic logic cycle_known(input logic [15:0] code);
		return code == `CYC_C0 || code == `CYC_C1 || code == `CYC_C3 || code == `CYC_C6;
	endfunction

	function automatic logic cycle_fast(input logic [15:0] code);
		return code == `CYC_C0 || code == `CYC_C1;
	endfunction

	// register bank, answered one cycle after the request
	always_comb begin
		nxt_range = range_ff;
		nxt_tsat_lim = tsat_lim_ff;
		nxt_cyc = cyc_ff;
		nxt_ratio = ratio_ff;
		nxt_ext = ext_ff;
		nxt_ack = link.req;
		nxt_rdata = 32'h0;
		if (link.req && link.we) begin
			unique case (link.idx)
				`IDX_TARGET_FLAG_A: nxt_range = link.wdata[29:0];
				`IDX_TSAT: nxt_tsat_lim = link.wdata[15:0];
				`IDX_CYC: nxt_cyc = link.wdata[15:0];
				`IDX_RATIO: nxt_ratio = link.wdata[15:0];
				`IDX_EXT: nxt_ext = link.wdata[15:0];
				default: nxt_ack = 1'b1;
			endcase
		end
		if (link.req && !link.we) begin
			unique case (link.idx)
				`IDX_TARGET_FLAG_A: nxt_rdata = {2'h0, range_ff};
				`IDX_TSAT: nxt_rdata = {16'h0, tsat_lim_ff};
				`IDX_CYC: nxt_rdata = {16'h0, cyc_ff};
				`IDX_RATIO: nxt_rdata = {16'h0, ratio_ff};
				`IDX_EXT: nxt_rdata = {16'h0, ext_ff};
				default: nxt_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			range_ff <= `RST_TARGET_FLAG_A;
			tsat_lim_ff <= `RST_TSAT;
			cyc_ff <= `RST_CYC;
			ratio_ff <= `RST_RATIO;
			ext_ff <= `RST_EXT;
			ack_ff <= 1'b0;
			rdata_ff <= 32'h0;
		end else begin
			range_ff <= nxt_range;
			tsat_lim_ff <= nxt_tsat_lim;
			cyc_ff <= nxt_cyc;
			ratio_ff <= nxt_ratio;
			ext_ff <= nxt_ext;
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
		end
	end

	assign link.ack = ack_ff;
	assign link.rdata = rdata_ff;

	// cycle timing: communication period, command update, control cycle
	always_comb begin
		logic [16:0] period;
		period = 17'(CYC6_CYCLES);
		unique case (cyc_ff)
			`CYC_C0: period = 17'(CYC0_CYCLES);
			`CYC_C1: period = 17'(CYC1_CYCLES);
			`CYC_C3: period = 17'(CYC3_CYCLES);
			default: period = 17'(CYC6_CYCLES);
		endcase
		nxt_comm_tick = 1'b0;
		nxt_comm_cnt = comm_cnt_ff + 17'h1;
		// a period shortened mid-count wraps at once instead of running to overflow
		if (comm_cnt_ff >= period - 17'h1) begin
			nxt_comm_cnt = 17'h0;
			nxt_comm_tick = 1'b1;
		end
		nxt_phase = phase_ff;
		nxt_cmd_upd = 1'b0;
		if (nxt_comm_tick) begin
			if (ratio_ff == `RATIO_TWO) begin
				nxt_phase = !phase_ff;
				nxt_cmd_upd = phase_ff;
			end else begin
				nxt_phase = 1'b0;
				nxt_cmd_upd = 1'b1;
			end
		end
		nxt_ctrl_tick = 1'b0;
		nxt_ctrl_cnt = ctrl_cnt_ff + 17'h1;
		if (ctrl_cnt_ff >= 17'(CTRL_CYCLES) - 17'h1) begin
			nxt_ctrl_cnt = 17'h0;
			nxt_ctrl_tick = 1'b1;
		end
		// only flagged: the device guarantees nothing for bad setups
		nxt_cfg_err = !cycle_known(cyc_ff) || (ratio_ff != `RATIO_ONE && ratio_ff != `RATIO_TWO)
			|| (ratio_ff == `RATIO_TWO && cyc_ff != `CYC_C0 && cyc_ff != `CYC_C3);
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			comm_cnt_ff <= 17'h0;
			ctrl_cnt_ff <= 17'h0;
			phase_ff <= 1'b0;
			comm_tick_ff <= 1'b0;
			cmd_upd_ff <= 1'b0;
			ctrl_tick_ff <= 1'b0;
			cfg_err_ff <= 1'b0;
		end else begin
			comm_cnt_ff <= nxt_comm_cnt;
			ctrl_cnt_ff <= nxt_ctrl_cnt;
			phase_ff <= nxt_phase;
			comm_tick_ff <= nxt_comm_tick;
			cmd_upd_ff <= nxt_cmd_upd;
			ctrl_tick_ff <= nxt_ctrl_tick;
			cfg_err_ff <= nxt_cfg_err;
		end
	end

	// monitoring: target_flag_a and torque saturation evaluated on the control cycle, setup outputs every clock
	always_comb begin
		logic [31:0] gap;
		gap = i_target_pos - i_command_pos;
		if (gap[31]) begin
			gap = 32'h0 - gap;
		end
		nxt_target_flag_a = target_flag_a_ff;
		nxt_sat_cnt = sat_cnt_ff;
		nxt_err = err_ff && !i_alarm_clr;
		if (nxt_ctrl_tick) begin
			nxt_target_flag_a = i_profile_position_mode && gap < {2'h0, range_ff};
			if (!i_torque_sat) begin
				nxt_sat_cnt = 16'h0;
			end else if (sat_cnt_ff < `TSAT_MAX) begin
				nxt_sat_cnt = sat_cnt_ff + 16'h1;
			end
			// set wins over a clear in the same cycle
			if (tsat_lim_ff != 16'h0 && i_torque_sat && nxt_sat_cnt >= tsat_lim_ff) begin
				nxt_err = 1'b1;
			end
		end
		nxt_frame = ext_ff[`EXT_FRAME];
		nxt_sync = ext_ff[`EXT_SYNC];
		nxt_scale = i_full_closed
			|| (ext_ff[`EXT_SCALE] && (!cycle_fast(cyc_ff) || i_no_operation_command));
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			target_flag_a_ff <= 1'b0;
			sat_cnt_ff <= 16'h0;
			err_ff <= 1'b0;
			frame_ff <= 1'b0;
			sync_ff <= 1'b0;
			scale_ff <= 1'b0;
		end else begin
			target_flag_a_ff <= nxt_target_flag_a;
			sat_cnt_ff <= nxt_sat_cnt;
			err_ff <= nxt_err;
			frame_ff <= nxt_frame;
			sync_ff <= nxt_sync;
			scale_ff <= nxt_scale;
		end
	end

	assign o_target_flag_a = target_flag_a_ff;
	assign o_torque_sat_err = err_ff;
	assign o_comm_tick = comm_tick_ff;
	assign o_cmd_update = cmd_upd_ff;
	assign o_ctrl_tick = ctrl_tick_ff;
	assign o_frame_32byte = frame_ff;
	assign o_full_sync = sync_ff;
	assign o_ext_scale_mon = scale_ff;
	assign o_cfg_err = cfg_err_ff;
endmodule

/* verif/link_cfg_props.sv */
// assertions on the register link between the two ends
`timescale 1ns/1ps
`include "link_cfg_params.svh"
module link_cfg_props (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// link signals
	input wire logic req,
	input wire logic we,
	input wire link_cfg_pkg::reg_idx_t idx,
	input wire logic [31:0] wdata,
	input wire logic ack,
	input wire logic [31:0] rdata
);
	logic [15:0] cyc_ff;
	logic [15:0] nxt_cyc;
	logic wcyc;
	assign wcyc = req && we && idx == `IDX_CYC;
	always_comb begin
		nxt_cyc = wcyc ? wdata[15:0] : cyc_ff;
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) cyc_ff <= `RST_CYC;
		else cyc_ff <= nxt_cyc;
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	chk_cycle_code_legal: assert property (wcyc |-> wdata[15:0] inside {0, 1, 3, 6})
		else $error("illegal cycle code forwarded");
	chk_ratio_two_gate: assert property (req && we && idx == `IDX_RATIO && wdata[15:0] == `RATIO_TWO
		|-> cyc_ff inside {`CYC_C0, `CYC_C3}) else $error("ratio two with wrong cycle");
	chk_ext_bits_zero: assert property (req && we && idx == `IDX_EXT |-> wdata[3:2] == 2'h0)
		else $error("reserved setup bits forwarded");
	chk_ack_one_later: assert property (req |=> ack ##1 !ack)
		else $error("ack not one cycle after req");
	chk_ack_has_req: assert property (ack |-> $past(req))
		else $error("ack without req");
	chk_req_single: assert property (req |=> !req)
		else $error("req longer than one cycle");
	chk_rdata_idle: assert property (!ack |-> rdata == 32'h0)
		else $error("rdata not zero while idle");
	chk_cycle_readback: assert property (ack && !$past(we) && $past(idx) == `IDX_CYC
		|-> rdata[15:0] inside {0, 1, 3, 6}) else $error("bad cycle code read");
	chk_ext_readback: assert property (ack && !$past(we) && $past(idx) == `IDX_EXT
		|-> rdata[3:2] == 2'h0) else $error("reserved setup bits read");
endmodule

/* verif/tb_servo_network_link_config_bank.sv */
// self-checking bench joining controller and device ends
`timescale 1ns/1ps
`include "link_cfg_params.svh"
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
	$display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
module tb_servo_network_link_config_bank;
	localparam int P0 = 20, P1 = 40, P3 = 60, P6 = 80, PC = 10;
	logic clk = 0, rst_n = 0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 32'h0, tpos = 32'h0, cpos = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic ppm = 0, tsat = 0, aclr = 0, fcl = 0, no_operation_command = 0;
	logic target_flag_a, terr, ctick, cupd, rtick, f32, fsync, smon, cerr;
	int err_count = 0, checks_done = 0, n;
	logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h6, 32'h1, 32'h0, 32'h6};
	logic [15:0] cc [4] = '{16'h0, 16'h1, 16'h3, 16'h6};
	int cp [4] = '{P0, P1, P3, P6};
	link_cfg_if link_cfg_if_inst();
	servo_link_cfg_ctrl servo_link_cfg_ctrl_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
		.i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready), .link(link_cfg_if_inst));
	servo_link_cfg_device #(.CYC0_CYCLES(P0), .CYC1_CYCLES(P1), .CYC3_CYCLES(P3), .CYC6_CYCLES(P6),
		.CTRL_CYCLES(PC)) servo_link_cfg_device_inst (.i_core_clk(clk), .i_rst_n(rst_n),
		.link(link_cfg_if_inst), .i_profile_position_mode(ppm), .i_target_pos(tpos), .i_command_pos(cpos),
		.i_torque_sat(tsat), .i_alarm_clr(aclr), .i_full_closed(fcl), .i_no_operation_command(no_operation_command),
		.o_target_flag_a(target_flag_a), .o_torque_sat_err(terr), .o_comm_tick(ctick), .o_cmd_update(cupd),
		.o_ctrl_tick(rtick), .o_frame_32byte(f32), .o_full_sync(fsync), .o_ext_scale_mon(smon),
		.o_cfg_err(cerr));
	link_cfg_props link_cfg_props_inst (.i_core_clk(clk), .i_rst_n(rst_n), .req(link_cfg_if_inst.req),
		.we(link_cfg_if_inst.we), .idx(link_cfg_if_inst.idx), .wdata(link_cfg_if_inst.wdata),
		.ack(link_cfg_if_inst.ack), .rdata(link_cfg_if_inst.rdata));
	always #4 clk = ~clk;
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// aw and w released one by one, each at its own taking edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		logic ta, tw;
		ta = 0;
		tw = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(ta && tw)) begin
			@(negedge clk);
			ta = ta | (awvalid & awready);
			tw = tw | (wvalid & wready);
			@(posedge clk);
			if (ta) awvalid <= 0;
			if (tw) wvalid <= 0;
		end
		do @(negedge clk); while (!bvalid);
		`CK(bresp, e)
		@(posedge clk);
		bready <= 0;
		repeat (2) @(negedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(negedge clk); while (!arready);
		@(posedge clk);
		arvalid <= 0;
		do @(negedge clk); while (!rvalid);
		`CK(rdata, v)
		`CK(rresp, e)
		@(posedge clk);
		rready <= 0;
	endtask
	function automatic logic sig(input int s);
		return s == 0 ? ctick : s == 1 ? cupd : rtick;
	endfunction
	// skips the first pulse, since a fresh setting may cut the running period short
	task automatic gap(input int s, output int g);
		repeat (2) begin
			@(negedge clk);
			while (!sig(s)) @(negedge clk);
		end
		g = 0;
		do begin
			@(negedge clk);
			g++;
		end while (!sig(s));
	endtask
	// waits for k control-cycle evaluations, one per pulse
	task automatic ticks(input int k);
		repeat (k) begin
			@(negedge clk);
			while (!rtick) @(negedge clk);
		end
	endtask
	initial begin
		#200us;
		err_count++;
		give_verdict();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1;
		for (int i = 0; i < 6; i++) rd(8'(i * 4), rv[i], `RESP_OKAY);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			wr(8'h08, 32'(cc[i]), `RESP_OKAY);
			rd(8'h08, 32'(cc[i]), `RESP_OKAY);
			gap(0, n);
			`CK(n, cp[i])
		end
		`CK(cerr, 1'b0)
		wr(8'h08, 32'h2, `RESP_SLVERR);
		wr(8'h14, 32'h0, `RESP_SLVERR);
		wr(8'h02, 32'h0, `RESP_SLVERR);
		rd(8'h18, 32'h0, `RESP_SLVERR);
		rd(8'h14, 32'h0003_0006, `RESP_OKAY);
		$display("test cycle done");
		wr(8'h0C, 32'h2, `RESP_SLVERR);
		wr(8'h08, 32'h3, `RESP_OKAY);
		wr(8'h0C, 32'h2, `RESP_OKAY);
		gap(1, n);
		`CK(n, 2 * P3)
		wr(8'h08, 32'h6, `RESP_SLVERR);
		`CK(cerr, 1'b0)
		wr(8'h0C, 32'h1, `RESP_OKAY);
		gap(1, n);
		`CK(n, P3)
		$display("test ratio done");
		wr(8'h10, 32'h1F, `RESP_OKAY);
		rd(8'h10, 32'h13, `RESP_OKAY);
		`CK({f32, fsync, smon}, 3'h7)
		wr(8'h08, 32'h0, `RESP_OKAY);
		`CK(smon, 1'b0)
		@(posedge clk) no_operation_command <= 1;
		repeat (3) @(negedge clk);
		`CK(smon, 1'b1)
		@(posedge clk) no_operation_command <= 0;
		wr(8'h10, 32'h0, `RESP_OKAY);
		`CK({f32, fsync, smon}, 3'h0)
		@(posedge clk) fcl <= 1;
		repeat (3) @(negedge clk);
		`CK(smon, 1'b1)
		$display("test setup done");
		gap(2, n);
		`CK(n, PC)
		wr(8'h00, 32'd100, `RESP_OKAY);
		@(posedge clk) ppm <= 1;
		tpos <= 32'd1000;
		cpos <= 32'd950;
		ticks(2);
		`CK(target_flag_a, 1'b1)
		@(posedge clk) cpos <= 32'd900;
		ticks(2);
		`CK(target_flag_a, 1'b0)
		@(posedge clk) cpos <= 32'd1040;
		ppm <= 0;
		ticks(2);
		`CK(target_flag_a, 1'b0)
		$display("test target_flag_a done");
		wr(8'h04, 32'h3, `RESP_OKAY);
		ticks(1);
		@(posedge clk) tsat <= 1;
		ticks(2);
		`CK(terr, 1'b0)
		ticks(1);
		`CK(terr, 1'b1)
		@(posedge clk) tsat <= 0;
		aclr <= 1;
		ticks(1);
		`CK(terr, 1'b0)
		@(posedge clk) aclr <= 0;
		wr(8'h04, 32'h0, `RESP_OKAY);
		@(posedge clk) tsat <= 1;
		ticks(5);
		`CK(terr, 1'b0)
		$display("test torque done");
		give_verdict();
	end
endmodule
